// *** common/fan_lut_pkg.sv ***
package fan_lut_pkg;
    // register word indices; the byte address is four times the index
    localparam logic [7:0] addr_temp_limit_1 = 8'h50;
    localparam logic [7:0] addr_duty_value_1 = 8'h51;
    localparam logic [7:0] addr_temp_limit_2 = 8'h52;
    localparam logic [7:0] addr_duty_value_2 = 8'h53;
    localparam logic [7:0] addr_lut_offset   = 8'h4e;
    localparam logic [7:0] addr_lut_control  = 8'h60;
    localparam logic [7:0] addr_lut_status   = 8'h64;

    // power-on values
    localparam logic [7:0] temp_limit_reset  = 8'h7f;
    localparam logic [7:0] duty_value_reset  = 8'h3f;
    localparam logic [5:0] offset_reset      = 6'h00;

    // field positions and masks
    localparam int         temp_half_pos     = 7;
    localparam logic [7:0] duty_low_mask     = 8'h3f;
    localparam logic [7:0] temp_low_mask     = 8'h7f;
    localparam int         ctl_prog_pos      = 0;
    localparam int         ctl_temp_hi_pos   = 1;
    localparam int         ctl_duty_hi_pos   = 2;
    localparam int         ctl_freq_hi_pos   = 3;
    localparam logic [3:0] ctl_reset         = 4'h0;

    // one lookup entry as the evaluator sees it
    typedef struct packed {
        logic [7:0] temp_limit;
        logic [7:0] duty;
    } lut_entry_s;

    // mode bits that steer the evaluator
    typedef struct packed {
        logic temp_hi_res;
        logic duty_hi_res;
        logic freq_22k5;
    } lut_mode_s;

    typedef enum logic [1:0] {
        sel_none   = 2'b00,
        sel_entry1 = 2'b01,
        sel_entry2 = 2'b10
    } lut_sel_e;
endpackage : fan_lut_pkg

// *** logic/lut_evaluate.sv ***
`timescale 1ns/1ps
// combinational evaluation of two entries against the remote temperature
module lut_evaluate
    import fan_lut_pkg::*;
(
    input  wire lut_entry_s entry1,
    input  wire lut_entry_s entry2,
    input  wire lut_mode_s  mode,
    input  wire logic [5:0] temp_offset,
    input  wire logic [8:0] remote_temp,
    input  wire logic [7:0] idle_duty,
    output logic [7:0]      duty_out,
    output lut_sel_e        sel
);
    // limit in half degrees, offset added, sign bit always taken as zero
    function automatic logic [9:0] eff_limit(input logic [7:0] raw,
                                             input logic       hi,
                                             input logic [5:0] off);
        logic [8:0] base;
        // bits 6:0 are whole degrees in both modes; bit 7 adds the half only in high-res
        base = hi ? {1'b0, raw[6:0], raw[temp_half_pos]} : {1'b0, raw[6:0], 1'b0};
        eff_limit = {1'b0, base} + {3'b000, off, 1'b0};
    endfunction : eff_limit

    // duty from an entry, upper bits only in high-res at 22.5 kHz
    function automatic logic [7:0] eff_duty(input logic [7:0] raw, input lut_mode_s m);
        eff_duty = (m.duty_hi_res && m.freq_22k5) ? raw : (raw & duty_low_mask);
    endfunction : eff_duty

    wire [9:0] lim1 = eff_limit(entry1.temp_limit, mode.temp_hi_res, temp_offset);
    wire [9:0] lim2 = eff_limit(entry2.temp_limit, mode.temp_hi_res, temp_offset);
    // low-res mode drops the half-degree bit of the reading
    wire [9:0] temp = mode.temp_hi_res ? {1'b0, remote_temp} : {1'b0, remote_temp[8:1], 1'b0};
    wire       over1 = temp > lim1;
    wire       over2 = temp > lim2;
    // pick the highest exceeded limit regardless of entry order
    wire       pick2 = over2 && (!over1 || lim2 >= lim1);
    wire       pick1 = over1 && !pick2;

    assign sel      = pick2 ? sel_entry2 : (pick1 ? sel_entry1 : sel_none);
    assign duty_out = pick2 ? eff_duty(entry2.duty, mode)
                    : (pick1 ? eff_duty(entry1.duty, mode) : idle_duty);
endmodule : lut_evaluate

// *** logic/fan_lut_entry_pairs.sv ***
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// - low-res temperature mode ignores limit bit 7 and reads it as zero.
// - high-res mode makes a 9-bit limit, 0 to 127.5 degrees, half steps.
// - low-res mode compares against limits of 0 to 127 degrees, one-degree steps.
// - temperature above an entry's limit selects that entry's duty as PWM value.
// - limits are non-negative; sign bit assumed zero.
// - lookup offset is added to every limit, reaching above 127 degrees.
// - low-res duty mode ignores duty bits 7:6 and reads them as zero.
// - high-res duty mode joins bits 7:6 with 5:0 into an 8-bit value.
// - duty extension bits act only at the 22.5 kHz PWM setting.
// - low-res PWM mode uses duty bits 5:0 alone.
// - each duty register sits at the address just above its limit register.
// - entries writable only while direct PWM programming bit is set.
// - lookup offset is unsigned, one-degree steps, at most 63 degrees.
module fan_lut_entry_pairs
    import fan_lut_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [8:0]  remote_temp,
    output logic [7:0]       pwm_value,
    output logic [1:0]       active_entry
);
    // stored registers
    logic [7:0] lut_temp_limit_1;
    logic [7:0] lut_duty_value_1;
    logic [7:0] lut_temp_limit_2;
    logic [7:0] lut_duty_value_2;
    logic [5:0] lut_temp_offset;
    logic [3:0] lut_control;
    // address phase capture
    logic       wr_pending;
    logic [7:0] wr_addr;
    // reading synchroniser, it comes from the conversion domain
    logic [8:0] temp_meta;
    logic [8:0] temp_sync;

    // readback view of a limit: bit 7 reads zero in low-res, the stored bit is kept
    function automatic logic [7:0] view_temp(input logic [7:0] raw, input logic hi);
        view_temp = hi ? raw : (raw & temp_low_mask);
    endfunction : view_temp

    // readback view of a duty: bits 7:6 read zero unless duty high-res is on
    function automatic logic [7:0] view_duty(input logic [7:0] raw, input logic hi);
        view_duty = hi ? raw : (raw & duty_low_mask);
    endfunction : view_duty

    // control bits: the entry write enable and the modes steering the evaluator
    wire        prog_enable = lut_control[ctl_prog_pos];
    lut_mode_s  mode;
    assign mode.temp_hi_res = lut_control[ctl_temp_hi_pos];
    assign mode.duty_hi_res = lut_control[ctl_duty_hi_pos];
    assign mode.freq_22k5   = lut_control[ctl_freq_hi_pos];

    // bus decode; registers sit one word apart, so the word index is haddr[9:2]
    wire        addr_phase = hsel && hready && htrans[1];
    wire [7:0]  reg_idx    = haddr[9:2];
    // anything above the index field or off word alignment maps to nothing
    wire        in_page    = (haddr[31:10] == '0) && (haddr[1:0] == '0);
    wire        entry_wr   = wr_pending && prog_enable;

    // per-register write strobes; entries need the programming bit, the rest do not
    wire        wr_temp1  = entry_wr && (wr_addr == addr_temp_limit_1);
    wire        wr_duty1  = entry_wr && (wr_addr == addr_duty_value_1);
    wire        wr_temp2  = entry_wr && (wr_addr == addr_temp_limit_2);
    wire        wr_duty2  = entry_wr && (wr_addr == addr_duty_value_2);
    wire        wr_offset = wr_pending && (wr_addr == addr_lut_offset);
    wire        wr_ctl    = wr_pending && (wr_addr == addr_lut_control);

    // readback views: limit bit 7 reads zero in low-res, duty bits 7:6 read zero unless duty high-res is on, whatever the PWM setting
    wire [7:0]  rd_temp1 = view_temp(lut_temp_limit_1, mode.temp_hi_res);
    wire [7:0]  rd_temp2 = view_temp(lut_temp_limit_2, mode.temp_hi_res);
    wire [7:0]  rd_duty1 = view_duty(lut_duty_value_1, mode.duty_hi_res);
    wire [7:0]  rd_duty2 = view_duty(lut_duty_value_2, mode.duty_hi_res);

    lut_entry_s entry1;
    lut_entry_s entry2;
    assign entry1.temp_limit = lut_temp_limit_1;
    assign entry1.duty       = lut_duty_value_1;
    assign entry2.temp_limit = lut_temp_limit_2;
    assign entry2.duty       = lut_duty_value_2;

    wire [7:0]  eval_duty;
    lut_sel_e   eval_sel;

    lut_evaluate u_eval (
        .entry1      (entry1),
        .entry2      (entry2),
        .mode        (mode),
        .temp_offset (lut_temp_offset),
        .remote_temp (temp_sync),
        .idle_duty   (8'h00),
        .duty_out    (eval_duty),
        .sel         (eval_sel)
    );

    // read mux, unmapped addresses read zero
    logic [7:0] next_rd;
    always_comb begin
        case (reg_idx)
            addr_temp_limit_1: next_rd = rd_temp1;
            addr_duty_value_1: next_rd = rd_duty1;
            addr_temp_limit_2: next_rd = rd_temp2;
            addr_duty_value_2: next_rd = rd_duty2;
            addr_lut_offset:   next_rd = {2'b00, lut_temp_offset};
            addr_lut_control:  next_rd = {4'h0, lut_control};
            addr_lut_status:   next_rd = {6'h00, eval_sel};
            default:           next_rd = 8'h00;
        endcase
    end

    // first synchroniser stage; nothing but the second stage reads it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            temp_meta <= '0;
        end else begin
            temp_meta <= remote_temp;
        end
    end

    // second stage; a reading torn across bits settles one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            temp_sync <= '0;
        end else begin
            temp_sync <= temp_meta;
        end
    end

    // a write is remembered until its data phase brings hwdata
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pending <= 1'b0;
        end else begin
            wr_pending <= addr_phase && hwrite && in_page;
        end
    end

    // word index of the pending write, only used while wr_pending is high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr <= '0;
        end else begin
            wr_addr <= reg_idx;
        end
    end

    // read data is launched in the address phase so it stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (addr_phase && !hwrite) begin
            // only the low byte carries a register, the rest reads zero
            hrdata <= in_page ? 32'(next_rd) : '0;
        end
    end

    // zero-wait slave: always ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // locked or unmapped writes still answer OKAY; software cannot see a refusal
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // limit of entry 1; all eight bits are stored whatever the mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lut_temp_limit_1 <= temp_limit_reset;
        end else if (wr_temp1) begin
            lut_temp_limit_1 <= hwdata[7:0];
        end
    end

    // duty of entry 1; a locked write is dropped silently
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lut_duty_value_1 <= duty_value_reset;
        end else if (wr_duty1) begin
            lut_duty_value_1 <= hwdata[7:0];
        end
    end

    // limit of entry 2
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lut_temp_limit_2 <= temp_limit_reset;
        end else if (wr_temp2) begin
            lut_temp_limit_2 <= hwdata[7:0];
        end
    end

    // duty of entry 2
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lut_duty_value_2 <= duty_value_reset;
        end else if (wr_duty2) begin
            lut_duty_value_2 <= hwdata[7:0];
        end
    end

    // offset is always writable; six bits cap it at 63 degrees by construction
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lut_temp_offset <= offset_reset;
        end else if (wr_offset) begin
            lut_temp_offset <= hwdata[5:0];
        end
    end

    // control is always writable, else the entries could never be unlocked
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lut_control <= ctl_reset;
        end else if (wr_ctl) begin
            lut_control <= hwdata[3:0];
        end
    end

    // duty toward the PWM generator, one cycle behind the evaluator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_value <= '0;
        end else begin
            pwm_value <= eval_duty;
        end
    end

    // which entry is driving the duty, registered beside it so both move together
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_entry <= '0;
        end else begin
            active_entry <= eval_sel;
        end
    end
endmodule : fan_lut_entry_pairs

// *** bench/fan_lut_properties.sv ***
`timescale 1ns/1ps
// watches only the top ports; the bus side is judged without knowing the decode
module fan_lut_properties
    import fan_lut_pkg::*;
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [8:0]  remote_temp,
    input wire logic [7:0]  pwm_value,
    input wire logic [1:0]  active_entry
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // a transfer taken at this edge
    wire logic req = hsel && hready && htrans[1];
    // no write and a steady reading: the selection has no cause to move
    sequence s_quiet; !(req && hwrite) && $stable(remote_temp); endsequence
    property p_ready; hreadyout; endproperty
    a_ready: assert property (p_ready) else $error("wait state inserted");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("error response");
    property p_byte_only; hrdata[31:8] == 24'h0; endproperty
    a_byte_only: assert property (p_byte_only) else $error("upper read bits set");
    property p_sel_legal; active_entry != 2'b11; endproperty
    a_sel_legal: assert property (p_sel_legal) else $error("two entries selected");
    property p_idle_zero; active_entry == 2'b00 |-> pwm_value == 8'h00; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("duty without entry");
    property p_steady; s_quiet [*5] |-> $stable(pwm_value) && $stable(active_entry); endproperty
    a_steady: assert property (p_steady) else $error("duty moved without cause");
    property p_unmapped; req && !hwrite && haddr[31:10] != 22'h0 |=> hrdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_hold; !(req && !hwrite) |=> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
endmodule : fan_lut_properties

bind fan_lut_entry_pairs fan_lut_properties i_props (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .remote_temp(remote_temp), .pwm_value(pwm_value), .active_entry(active_entry));

// *** bench/tb_fan_lut_entry_pairs.sv ***
`timescale 1ns/1ps
module tb_fan_lut_entry_pairs;
    import fan_lut_pkg::*;
    // one setting of the table, the reading, and the duty and entry it must give
    typedef struct packed {
        logic [3:0] ctl; logic [7:0] t1; logic [7:0] d1; logic [7:0] t2; logic [7:0] d2;
        logic [5:0] off; logic [8:0] temp; logic [7:0] pwm; logic [1:0] sel;
    } row_s;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, active_entry;
    logic [2:0]  hsize;
    logic [8:0]  remote_temp;
    logic [7:0]  pwm_value;
    int          mismatches, check_count;
    row_s        rows [10];

    // single slave, so its own ready closes the loop
    fan_lut_entry_pairs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .remote_temp(remote_temp),
        .pwm_value(pwm_value), .active_entry(active_entry));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task conclude;
        if (mismatches == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // one whole-word transfer; the register index times four is the byte address
    task bus(input logic w, input logic [13:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {16'h0, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus

    task rdchk(input logic [13:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 32'h0);
        check(what, exp, rd);
    endtask : rdchk

    // control goes first so that the programming bit opens the entries
    task load(input row_s r);
        bus(1'b1, addr_lut_control, {28'h0, r.ctl});
        bus(1'b1, addr_temp_limit_1, {24'h0, r.t1});
        bus(1'b1, addr_duty_value_1, {24'h0, r.d1});
        bus(1'b1, addr_temp_limit_2, {24'h0, r.t2});
        bus(1'b1, addr_duty_value_2, {24'h0, r.d2});
        bus(1'b1, addr_lut_offset, {26'h0, r.off});
        remote_temp <= r.temp;
        repeat (6) @(posedge hclk);
    endtask : load

    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = 32'h0; remote_temp = 9'h0; mismatches = 0; check_count = 0;
        rows = '{'{4'h1, 8'h14, 8'h10, 8'h28, 8'hd5, 6'h00, 9'd60, 8'h10, 2'd1},
                 '{4'h1, 8'h14, 8'h10, 8'h28, 8'hd5, 6'h00, 9'd82, 8'h15, 2'd2},
                 '{4'hd, 8'h14, 8'h10, 8'h28, 8'hd5, 6'h00, 9'd82, 8'hd5, 2'd2},
                 '{4'h5, 8'h14, 8'h10, 8'h28, 8'hd5, 6'h00, 9'd82, 8'h15, 2'd2},
                 '{4'h3, 8'h14, 8'h10, 8'ha7, 8'hd5, 6'h00, 9'd81, 8'h15, 2'd2},
                 '{4'h1, 8'h14, 8'h10, 8'h28, 8'hd5, 6'h00, 9'd81, 8'h10, 2'd1},
                 '{4'h1, 8'h14, 8'h10, 8'h28, 8'hd5, 6'h0a, 9'd82, 8'h10, 2'd1},
                 '{4'h1, 8'h14, 8'h10, 8'h28, 8'hd5, 6'h00, 9'd20, 8'h00, 2'd0},
                 '{4'h1, 8'h28, 8'h10, 8'h14, 8'h15, 6'h00, 9'd82, 8'h10, 2'd1},
                 '{4'h1, 8'h00, 8'h22, 8'h7f, 8'h3f, 6'h3f, 9'd128, 8'h22, 2'd1}};
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            load(rows[i]);
            check("pwm_value", rows[i].pwm, pwm_value);
            check("active_entry", rows[i].sel, active_entry);
            rdchk(addr_lut_status, rows[i].sel, "status");
        end
        // stored bits survive; only the readback hides them in low resolution
        bus(1'b1, addr_temp_limit_1, 32'hff);
        bus(1'b1, addr_duty_value_1, 32'hff);
        rdchk(addr_temp_limit_1, 32'h7f, "limit readback");
        rdchk(addr_duty_value_1, 32'h3f, "duty readback");
        bus(1'b1, addr_lut_control, 32'h7);
        rdchk(addr_temp_limit_1, 32'hff, "limit readback");
        rdchk(addr_duty_value_1, 32'hff, "duty readback");
        rdchk(14'h3000, 32'h0, "unmapped");
        // second reset in mid-run, then a write while the entries are locked
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rdchk(14'(addr_temp_limit_1 + i), i[0] ? 32'h3f : 32'h7f, "por");
        end
        bus(1'b1, addr_temp_limit_1, 32'h11);
        rdchk(addr_temp_limit_1, 32'h7f, "locked write");
        conclude;
    end

    // the whole sequence takes well under 2000 cycles; allow fifteen times that
    initial begin
        #3000000;
        mismatches++;
        conclude;
    end
endmodule : tb_fan_lut_entry_pairs
